// ### flash_params.svh
// Purpose: constants for the parallel flash host controller
// Assumes: 40 MHz mclk
// Notes: times in ns, us or ms as named; cycle counts derived below
// Function
// - read only with chip select and gate low
// - write strobe high before and during reads
// - program: two unlocks, setup, then address/data
// - erase: unlocks, setup, unlocks, sector command
// - host erases sector before reprogramming it; the controller sends a program command without erasing first
// - erase end seen by polling or toggle
// - lock: select, strobe low, gate/id high voltage
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

`define MCLK_MHZ 40
`define CYC_UP(ns) (((ns) * `MCLK_MHZ + 999) / 1000)

`define T_RC_NS 70
`define T_DF_NS 20
`define T_WP_NS 35
`define T_AH_NS 45
`define T_WPH_NS 35
`define T_SYNC_CYC 4
`define RD_CYC (`CYC_UP(`T_RC_NS) + `T_SYNC_CYC)
`define DF_CYC `CYC_UP(`T_DF_NS)
`define WP_CYC `CYC_UP(`T_WP_NS)
`define HI_CYC ((`T_AH_NS > `T_WPH_NS) ? `CYC_UP(`T_AH_NS) : `CYC_UP(`T_WPH_NS))

`define T_LOCK_US 10
`define LOCK_CYC (`T_LOCK_US * `MCLK_MHZ)
`define T_PROG_US 20
`define PROG_TMO_CYC (2 * `T_PROG_US * `MCLK_MHZ)
`define T_ERASE_MS 10
`define ERASE_TMO_CYC (2 * `T_ERASE_MS * `MCLK_MHZ * 1000)

`define UNLOCK1_ADDR 17'h05555
`define UNLOCK2_ADDR 17'h02aaa
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_DATA 8'h55
`define PROG_SETUP 8'ha0
`define ERASE_SETUP 8'h80
`define SECTOR_ERASE 8'h30
`define PROG_STEPS 3'd4
`define ERASE_STEPS 3'd6
`define POLL_BIT 7
`define TOGGLE_BIT 6

`endif

// ### flash_pkg.sv
// Purpose: types shared by the flash host controller
// Assumes: flash_params.svh provides the numbers
// Notes: none
`include "flash_params.svh"
package flash_pkg;
  typedef enum logic [2:0] {
    op_read, op_program, op_erase, op_id_read, op_lock
  } op_t;
  typedef enum logic [2:0] {
    s_idle, s_wr_lo, s_wr_hi, s_rd_lo, s_rd_hi, s_lock
  } state_t;
endpackage

// ### flash_sync3.sv
// Purpose: three-stage synchroniser for flash data pins
// Assumes: input is asynchronous to mclk
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module flash_sync3 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ### flash_host_ctrl.sv
// Purpose: host-side controller driving a byte-wide parallel flash
// Assumes: one flash on the pins; external switches make high voltage
// Notes: one command at a time; program/erase wait for completion
`timescale 1ns/1ps
`default_nettype none
`include "flash_params.svh"
module flash_host_ctrl #(
  parameter int unsigned ERASE_TMO_CYC = `ERASE_TMO_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire flash_pkg::op_t cmd_op,
  input wire logic [16:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  // answer
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic resp_err,
  // flash pins
  output logic [16:0] flash_addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  output logic oe_hv_en,
  output logic id_voltage_pin_hv
);
  import flash_pkg::*;

  state_t state_q, state_d;
  op_t op_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic [2:0] step_q, step_d;
  logic [8:0] cnt_q;
  logic [19:0] tmo_q;
  logic poll_q, have_prev_q, prev_tog_q;
  logic [7:0] cap_q;
  logic [7:0] data_s;
  logic cnt_done, last_step, settled, tmo_hit, poll_end;
  logic [16:0] seq_addr;
  logic [7:0] seq_data;
  logic [16:0] take_addr;
  op_t live_op;

  flash_sync3 #(.WIDTH(8)) u_dq_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(dq_in),
    .dout(data_s)
  );

  assign cmd_ready = (state_q == s_idle);
  // on the take cycle the registers still hold the previous command
  assign take_addr = (cmd_op == op_id_read) ? {16'h0000, cmd_addr[0]} : cmd_addr;
  assign live_op = cmd_ready ? cmd_op : op_q;
  assign cnt_done = (cnt_q == 9'h000);
  assign last_step = (step_q == ((op_q == op_erase) ? `ERASE_STEPS : `PROG_STEPS) - 3'd1);
  assign tmo_hit = (tmo_q == 20'h00000);
  // completion: toggle flag stopped and poll bit shows the written value for program, or 1 for erase
  assign settled = have_prev_q && (cap_q[`TOGGLE_BIT] == prev_tog_q) &&
                   (cap_q[`POLL_BIT] == ((op_q == op_program) ? wdata_q[`POLL_BIT] : 1'b1));
  assign poll_end = settled || tmo_hit;

  // command words for each write of a sequence
  always_comb begin
    seq_addr = `UNLOCK1_ADDR;
    seq_data = `UNLOCK1_DATA;
    unique case (step_d)
      3'd1, 3'd4: begin
        seq_addr = `UNLOCK2_ADDR;
        seq_data = `UNLOCK2_DATA;
      end
      3'd2: seq_data = (op_q == op_erase) ? `ERASE_SETUP : `PROG_SETUP;
      3'd3: begin
        if (op_q == op_program) begin
          seq_addr = addr_q;
          seq_data = wdata_q;
        end
      end
      3'd5: begin
        seq_addr = addr_q;
        seq_data = `SECTOR_ERASE;
      end
      default: ;
    endcase
  end

  // sequencing of bus cycles
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    unique case (state_q)
      s_idle: begin
        step_d = 3'd0;
        if (cmd_valid) begin
          unique case (cmd_op)
            op_program, op_erase: state_d = s_wr_lo;
            op_lock: state_d = s_lock;
            default: state_d = s_rd_lo;
          endcase
        end
      end
      s_wr_lo: if (cnt_done) state_d = s_wr_hi;
      s_wr_hi: begin
        if (cnt_done) begin
          state_d = last_step ? s_rd_lo : s_wr_lo;
          step_d = last_step ? step_q : step_q + 3'd1;
        end
      end
      s_rd_lo: if (cnt_done) state_d = s_rd_hi;
      s_rd_hi: if (cnt_done) state_d = (poll_q && !poll_end) ? s_rd_lo : s_idle;
      s_lock: if (cnt_done) state_d = s_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= s_idle;
      step_q <= 3'd0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
    end
  end

  // interval counter, reloaded on each state change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
    end else if (state_d != state_q) begin
      unique case (state_d)
        s_wr_lo: cnt_q <= 9'(`WP_CYC - 1);
        s_wr_hi: cnt_q <= 9'(`HI_CYC - 1);
        s_rd_lo: cnt_q <= 9'(`RD_CYC - 1);
        s_rd_hi: cnt_q <= 9'(`DF_CYC);
        s_lock: cnt_q <= 9'(`LOCK_CYC - 1);
        default: cnt_q <= 9'h000;
      endcase
    end else if (!cnt_done) begin
      cnt_q <= cnt_q - 9'h001;
    end
  end

  // command capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= op_read;
      addr_q <= 17'h00000;
      wdata_q <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      op_q <= cmd_op;
      addr_q <= take_addr;
      wdata_q <= cmd_wdata;
    end
  end

  // status polling after program or erase, bounded by a timeout
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      poll_q <= 1'b0;
      have_prev_q <= 1'b0;
      prev_tog_q <= 1'b0;
      tmo_q <= 20'h00000;
    end else if (state_q == s_wr_hi && state_d == s_rd_lo) begin
      poll_q <= 1'b1;
      have_prev_q <= 1'b0;
      tmo_q <= (op_q == op_erase) ? 20'(ERASE_TMO_CYC) : 20'(`PROG_TMO_CYC);
    end else if (state_d == s_idle) begin
      poll_q <= 1'b0;
    end else begin
      if (poll_q && !tmo_hit) begin
        tmo_q <= tmo_q - 20'h00001;
      end
      if (state_q == s_rd_hi && cnt_done) begin
        have_prev_q <= 1'b1;
        prev_tog_q <= cap_q[`TOGGLE_BIT];
      end
    end
  end

  // read data sampled at the end of the gate-low interval
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= 8'h00;
    end else if (state_q == s_rd_lo && cnt_done) begin
      cap_q <= data_s;
    end
  end

  // answer pulse on return to idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_rdata <= 8'h00;
      resp_err <= 1'b0;
    end else begin
      resp_valid <= (state_q != s_idle) && (state_d == s_idle);
      if ((state_q != s_idle) && (state_d == s_idle)) begin
        resp_rdata <= cap_q;
        resp_err <= poll_q && !settled;
      end
    end
  end

  // pin drivers, registered from the next state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      dq_out <= 8'h00;
      flash_addr <= 17'h00000;
      oe_hv_en <= 1'b0;
      id_voltage_pin_hv <= 1'b0;
    end else begin
      ce_n <= !(state_d inside {s_wr_lo, s_rd_lo, s_lock});
      oe_n <= (state_d != s_rd_lo);
      we_n <= !(state_d inside {s_wr_lo, s_lock});
      dq_oe <= (state_d inside {s_wr_lo, s_wr_hi});
      if (state_d == s_wr_lo) begin
        dq_out <= seq_data;
        flash_addr <= seq_addr;
      end else if (state_d == s_rd_lo) begin
        flash_addr <= cmd_ready ? take_addr : addr_q;
      end
      oe_hv_en <= (state_d == s_lock);
      id_voltage_pin_hv <= (state_d == s_lock) || (live_op == op_id_read && state_d != s_idle);
    end
  end

  // helper: writes issued since the command was taken
  logic [2:0] wr_cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt_q <= 3'd0;
    end else if (cmd_valid && cmd_ready) begin
      wr_cnt_q <= 3'd0;
    end else if (state_q == s_wr_lo && state_d == s_wr_hi) begin
      wr_cnt_q <= wr_cnt_q + 3'd1;
    end
  end

  AST_READ_WE_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    (!oe_n && !ce_n) |-> we_n && $past(we_n)) else $error("write strobe low during read");
  AST_NO_DRIVE_ON_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    !oe_n |-> !dq_oe && !ce_n) else $error("data driven while gate low");
  AST_READ_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(oe_n) |-> !oe_n [*7] ##1 oe_n) else $error("read gate width wrong");
  AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!we_n && $past(!we_n)) |-> $stable(flash_addr) && $stable(dq_out)) else $error("address moved");
  AST_DATA_AT_RISE: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(we_n) && !$past(oe_hv_en)) |-> dq_oe && $stable(dq_out) ##1 dq_oe) else $error("data dropped");
  AST_PROG_FOUR: assert property (@(posedge mclk) disable iff (!rst_n)
    (resp_valid && op_q == op_program) |-> wr_cnt_q == 3'd4) else $error("program not four writes");
  AST_ERASE_SIX: assert property (@(posedge mclk) disable iff (!rst_n)
    (resp_valid && op_q == op_erase) |-> wr_cnt_q == 3'd6) else $error("erase not six writes");
  AST_LOCK_LEVELS: assert property (@(posedge mclk) disable iff (!rst_n)
    oe_hv_en |-> !ce_n && !we_n && oe_n && id_voltage_pin_hv) else $error("lock levels wrong");
  AST_PROG_TRUE: assert property (@(posedge mclk) disable iff (!rst_n)
    (resp_valid && !resp_err && op_q == op_program) |-> resp_rdata[7] == wdata_q[7])
    else $error("program done with inverted poll bit");
  AST_ID_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
    (id_voltage_pin_hv && !oe_n) |-> flash_addr[16:1] == 16'h0000) else $error("id read address");

  COV_PROGRAM: cover property (@(posedge mclk) disable iff (!rst_n)
    resp_valid && !resp_err && op_q == op_program);
  COV_ERASE: cover property (@(posedge mclk) disable iff (!rst_n)
    resp_valid && !resp_err && op_q == op_erase);
  COV_TIMEOUT: cover property (@(posedge mclk) disable iff (!rst_n) resp_valid && resp_err);
  COV_LOCK: cover property (@(posedge mclk) disable iff (!rst_n) $fell(oe_hv_en));
endmodule
`default_nettype wire

// ### flash_dev_model.sv
// Purpose: behavioural byte-wide flash as seen at the host pins
// Assumes: clockless and edge ordered; busy times in ns
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int PROG_NS = 2500,
  parameter int ERASE_NS = 15000,
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary
  parameter logic [7:0] DEV_CODE = 8'hc5 // arbitrary
) (
  // pins
  input wire logic [16:0] flash_addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic oe_hv_en,
  input wire logic id_voltage_pin_hv,
  output logic [7:0] dq_in,
  // fault control: operation never completes
  input wire logic hang
);
  logic [7:0] mem [0:131071];
  logic [16:0] la, pa;
  logic [7:0] pd;
  logic [2:0] s;
  logic busy, ers, tgl, locked;
  int bns;
  wire wr = ~ce_n & ~we_n & ~oe_hv_en;
  wire rd = ~ce_n & ~oe_n & we_n;
  wire lk = ~ce_n & ~we_n & oe_hv_en & id_voltage_pin_hv;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {s, busy, ers, tgl, locked, dq_in} = '0;
    {la, pa, pd, bns} = '0;
  end
  task start(input logic e, input logic [7:0] d, input int t);
    if (!(locked && la >= 17'h1e000)) begin
      pa = la;
      pd = d;
      ers = e;
      bns = t;
      busy = 1'b1;
    end
  endtask
  always @(posedge lk) locked = 1'b1;
  always @(posedge wr) la = flash_addr;
  // unexpected writes drop the sequence
  always @(negedge wr) begin
    if (busy) s = 3'd0;
    else case (s)
      3'd0: s = (la == 17'h05555 && dq_out == 8'haa) ? 3'd1 : 3'd0;
      3'd1: s = (la == 17'h02aaa && dq_out == 8'h55) ? 3'd2 : 3'd0;
      3'd2: s = (la != 17'h05555) ? 3'd0 : (dq_out == 8'ha0) ? 3'd3 : (dq_out == 8'h80) ? 3'd4 : 3'd0;
      3'd3: begin
        start(1'b0, dq_out, PROG_NS);
        s = 3'd0;
      end
      3'd4: s = (la == 17'h05555 && dq_out == 8'haa) ? 3'd5 : 3'd0;
      3'd5: s = (la == 17'h02aaa && dq_out == 8'h55) ? 3'd6 : 3'd0;
      3'd6: begin
        if (dq_out == 8'h30) start(1'b1, 8'hff, ERASE_NS);
        s = 3'd0;
      end
      default: s = 3'd0;
    endcase
  end
  always @(posedge rd) if (busy) tgl = ~tgl;
  always begin
    wait (busy);
    #(bns);
    wait (!hang);
    if (ers) for (int i = 0; i < 512; i++) mem[{pa[16:9], i[8:0]}] = 8'hff;
    else mem[pa] = mem[pa] & pd;
    busy = 1'b0;
  end
  always @(rd or flash_addr or busy or tgl or id_voltage_pin_hv) begin
    if (!rd) dq_in = ~dq_in;
    else if (id_voltage_pin_hv) dq_in = flash_addr[0] ? DEV_CODE : MAKER_CODE;
    else if (busy) dq_in = {~pd[7], tgl, mem[pa][5:0]};
    else dq_in = mem[flash_addr];
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural flash model on the pins
// Notes: erase timeout shortened to 2000 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary
  localparam logic [7:0] DEV = 8'hc5; // arbitrary
  logic mclk, rst_n, cmd_valid, cmd_ready, resp_valid, resp_err, hang;
  logic ce_n, oe_n, we_n, dq_oe, oe_hv_en, id_voltage_pin_hv;
  op_t cmd_op;
  logic [16:0] cmd_addr, flash_addr;
  logic [7:0] cmd_wdata, resp_rdata, dq_out, dq_in;
  logic [31:0] rs;
  logic [7:0] sh [logic [16:0]];
  int miscompares, checked;
  flash_host_ctrl #(.ERASE_TMO_CYC(2000)) u_flash_host_ctrl (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_err(resp_err),
    .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .oe_hv_en(oe_hv_en), .id_voltage_pin_hv(id_voltage_pin_hv));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) u_flash_dev_model (.flash_addr(flash_addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .oe_hv_en(oe_hv_en),
    .id_voltage_pin_hv(id_voltage_pin_hv), .dq_in(dq_in), .hang(hang));
  always #12.5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] exp_of(input logic [16:0] a);
    return sh.exists(a) ? sh[a] : 8'hff;
  endfunction
  task print_verdict;
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_cmd(input op_t op, input logic [16:0] a, input logic [7:0] d);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      print_verdict;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (resp_valid !== 1'b1) begin
      miscompares++;
      print_verdict;
    end
  endtask
  task automatic rd_chk(input logic [16:0] a);
    do_cmd(op_read, a, 8'h00);
    check(resp_rdata, exp_of(a));
  endtask
  task automatic prog(input logic [16:0] a, input logic [7:0] d);
    do_cmd(op_program, a, d);
    sh[a] = exp_of(a) & d;
    check({7'h0, resp_err}, 8'h00);
    check(resp_rdata, sh[a]);
    rd_chk(a);
  endtask
  // the host must never drive the data lines or strobe a write during a read
  always @(negedge mclk) begin
    if (rst_n === 1'b1 && ce_n === 1'b0 && oe_n === 1'b0 && oe_hv_en === 1'b0)
      check({6'h0, we_n, dq_oe}, 8'h02);
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = op_read;
    cmd_addr = '0;
    cmd_wdata = '0;
    hang = 1'b0;
    rs = 32'ha614;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    check({4'h0, ce_n, oe_n, we_n, dq_oe}, 8'h0e);
    rd_chk(17'h00000);
    rd_chk(17'h1ffff);
    prog(17'h00000, 8'h00);
    prog(17'h1ffff, 8'h7f);
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      prog({1'b0, rs[15:0]}, rs[23:16]);
    end
    do_cmd(op_erase, 17'h1fe55, 8'h00);
    foreach (sh[a]) if (a[16:9] == 8'hff) sh[a] = 8'hff;
    check({7'h0, resp_err}, 8'h00);
    check({7'h0, resp_rdata[7]}, 8'h01);
    rd_chk(17'h1ffff);
    rd_chk(17'h00000);
    do_cmd(op_id_read, 17'h00000, 8'h00);
    check(resp_rdata, MAKER);
    do_cmd(op_id_read, 17'h00001, 8'h00);
    check(resp_rdata, DEV);
    rd_chk(17'h00001);
    do_cmd(op_lock, 17'h00000, 8'h00);
    do_cmd(op_program, 17'h1e000, 8'h00);
    check({7'h0, resp_err}, 8'h01);
    rd_chk(17'h1e000);
    hang = 1'b1;
    do_cmd(op_program, 17'h00100, 8'h00);
    check({7'h0, resp_err}, 8'h01);
    hang = 1'b0;
    print_verdict;
  end
endmodule
`default_nettype wire
